// [hw/cie_core.sv]
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
// Executes single instructions issued through the command register
module cie_core #(
    parameter int WDT_W = 8,
    parameter int PRESC_W = 8
) (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic [cie_pkg::AXI_AW-1:0] I_S_AXI_AWADDR,
    input wire logic I_S_AXI_AWVALID,
    output logic O_S_AXI_AWREADY,
    input wire logic [cie_pkg::AXI_DW-1:0] I_S_AXI_WDATA,
    input wire logic [cie_pkg::AXI_SW-1:0] I_S_AXI_WSTRB,
    input wire logic I_S_AXI_WVALID,
    output logic O_S_AXI_WREADY,
    output logic [1:0] O_S_AXI_BRESP,
    output logic O_S_AXI_BVALID,
    input wire logic I_S_AXI_BREADY,
    input wire logic [cie_pkg::AXI_AW-1:0] I_S_AXI_ARADDR,
    input wire logic I_S_AXI_ARVALID,
    output logic O_S_AXI_ARREADY,
    output logic [cie_pkg::AXI_DW-1:0] O_S_AXI_RDATA,
    output logic [1:0] O_S_AXI_RRESP,
    output logic O_S_AXI_RVALID,
    input wire logic I_S_AXI_RREADY,
    output logic O_STACK_PUSH,
    output logic [cie_pkg::PC_W-1:0] O_STACK_TOP
);
    import cie_pkg::*;

    // Byte-lane merge, used by every writable register
    function automatic logic [AXI_DW-1:0] merge_strb(input logic [AXI_DW-1:0] old_v,
                                                     input logic [AXI_DW-1:0] new_v,
                                                     input logic [AXI_SW-1:0] strb);
        logic [AXI_DW-1:0] res;
        res = old_v;
        for (int i = 0; i < AXI_SW; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Mapped offsets
    function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
        return (a == REG_CMD) || (a == REG_STATUS) || (a == REG_ACC) || (a == REG_PAGE)
            || (a == REG_PC) || (a == REG_WDT) || (a == REG_STACK) || (a == REG_FADDR)
            || (a == REG_FDATA) || (a == REG_CYCLES);
    endfunction

    // Opcodes that read a file register operand
    function automatic logic uses_file(input logic [3:0] op);
        return (op == OPC_COMPLEMENT) || (op == OPC_DECREMENT) || (op == OPC_DEC_SKIP);
    endfunction

    // Write channel capture
    logic aw_full_reg; // Address held
    logic [AXI_AW-1:0] aw_addr_reg;
    logic w_full_reg; // Data held
    logic [AXI_DW-1:0] w_data_reg;
    logic [AXI_SW-1:0] w_strb_reg;
    logic wr_do; // Apply the write this cycle
    logic [AXI_DW-1:0] wr_val; // Merged into old value
    logic [AXI_DW-1:0] wr_old; // Current value at write address
    // Read channel capture
    logic ar_full_reg;
    logic [AXI_AW-1:0] ar_addr_reg;
    logic rd_do;
    logic settle_reg; // Memory read data not yet valid
    logic [AXI_DW-1:0] rd_data;
    // Core state
    cie_state_t state_reg;
    cie_instr_t instr_reg;
    logic [AXI_DW-1:0] cmd_reg;
    logic [DATA_W-1:0] acc_reg;
    logic [PAGE_W-1:0] page_reg;
    logic [PC_W-1:0] pc_reg;
    logic z_reg;
    logic pd_reg;
    logic to_reg;
    logic [WDT_W-1:0] wdt_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic [FILE_AW-1:0] faddr_reg;
    logic [AXI_DW-1:0] cycles_reg;
    // Memory ports
    logic mem_we;
    logic [FILE_AW-1:0] mem_waddr;
    logic [DATA_W-1:0] mem_wdata;
    logic [FILE_AW-1:0] mem_raddr;
    logic [DATA_W-1:0] mem_rdata;
    // Execution results
    logic [DATA_W-1:0] ex_res;
    logic ex_wr_file;
    logic ex_wr_acc;
    logic ex_z_upd;
    logic ex_wdt_clr;
    logic ex_second; // Needs a second instruction cycle
    logic in_exec;
    logic start;
    logic timeout;

    assign in_exec = (state_reg == EX_EXEC);
    assign start = wr_do && (aw_addr_reg == REG_CMD);
    // Writes and reads wait for an idle core so the file array has one user
    assign wr_do = aw_full_reg && w_full_reg && !O_S_AXI_BVALID && (state_reg == EX_IDLE);
    assign rd_do = ar_full_reg && !O_S_AXI_RVALID && (state_reg == EX_IDLE) && !settle_reg;
    assign timeout = (&presc_reg) && (&wdt_reg);

    // Write address channel
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            O_S_AXI_AWREADY <= 1'b0;
        end else if (O_S_AXI_AWREADY && I_S_AXI_AWVALID) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= I_S_AXI_AWADDR;
            O_S_AXI_AWREADY <= 1'b0;
        end else if (wr_do) begin
            aw_full_reg <= 1'b0;
            O_S_AXI_AWREADY <= 1'b1;
        end else begin
            O_S_AXI_AWREADY <= !aw_full_reg;
        end
    end

    // Write data channel
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            O_S_AXI_WREADY <= 1'b0;
        end else if (O_S_AXI_WREADY && I_S_AXI_WVALID) begin
            w_full_reg <= 1'b1;
            w_data_reg <= I_S_AXI_WDATA;
            w_strb_reg <= I_S_AXI_WSTRB;
            O_S_AXI_WREADY <= 1'b0;
        end else if (wr_do) begin
            w_full_reg <= 1'b0;
            O_S_AXI_WREADY <= 1'b1;
        end else begin
            O_S_AXI_WREADY <= !w_full_reg;
        end
    end

    // Write response, unmapped offsets answer with an error
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            O_S_AXI_BVALID <= 1'b0;
            O_S_AXI_BRESP <= RESP_OKAY;
        end else if (wr_do) begin
            O_S_AXI_BVALID <= 1'b1;
            O_S_AXI_BRESP <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (I_S_AXI_BREADY) begin
            O_S_AXI_BVALID <= 1'b0;
        end
    end

    // Read address channel
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            ar_full_reg <= 1'b0;
            ar_addr_reg <= '0;
            O_S_AXI_ARREADY <= 1'b0;
        end else if (O_S_AXI_ARREADY && I_S_AXI_ARVALID) begin
            ar_full_reg <= 1'b1;
            ar_addr_reg <= I_S_AXI_ARADDR;
            O_S_AXI_ARREADY <= 1'b0;
        end else if (rd_do) begin
            ar_full_reg <= 1'b0;
            O_S_AXI_ARREADY <= 1'b1;
        end else begin
            O_S_AXI_ARREADY <= !ar_full_reg;
        end
    end

    // Hold reads one cycle after a write or execution, array output lags
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            settle_reg <= 1'b1;
        end else begin
            settle_reg <= wr_do || (state_reg != EX_IDLE);
        end
    end

    // Read mux
    always_comb begin
        rd_data = '0;
        case (ar_addr_reg)
            REG_CMD: rd_data = cmd_reg;
            REG_STATUS: begin
                rd_data[ST_Z_BIT] = z_reg;
                rd_data[ST_PD_BIT] = pd_reg;
                rd_data[ST_TO_BIT] = to_reg;
                rd_data[ST_BUSY_BIT] = (state_reg != EX_IDLE);
            end
            REG_ACC: rd_data[DATA_W-1:0] = acc_reg;
            REG_PAGE: rd_data[PAGE_W-1:0] = page_reg;
            REG_PC: rd_data[PC_W-1:0] = pc_reg;
            REG_WDT: begin
                rd_data[WDT_W-1:0] = wdt_reg;
                rd_data[WDT_PRESC_LSB +: PRESC_W] = presc_reg;
            end
            REG_STACK: rd_data[PC_W-1:0] = O_STACK_TOP;
            REG_FADDR: rd_data[FILE_AW-1:0] = faddr_reg;
            REG_FDATA: rd_data[DATA_W-1:0] = mem_rdata;
            REG_CYCLES: rd_data = cycles_reg;
            default: rd_data = '0;
        endcase
    end

    // Read response
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            O_S_AXI_RVALID <= 1'b0;
            O_S_AXI_RDATA <= '0;
            O_S_AXI_RRESP <= RESP_OKAY;
        end else if (rd_do) begin
            O_S_AXI_RVALID <= 1'b1;
            O_S_AXI_RDATA <= rd_data;
            O_S_AXI_RRESP <= addr_mapped(ar_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (I_S_AXI_RREADY) begin
            O_S_AXI_RVALID <= 1'b0;
        end
    end

    // Old value of the addressed register for byte merging
    always_comb begin
        wr_old = '0;
        case (aw_addr_reg)
            REG_CMD: wr_old = cmd_reg;
            REG_ACC: wr_old[DATA_W-1:0] = acc_reg;
            REG_PAGE: wr_old[PAGE_W-1:0] = page_reg;
            REG_PC: wr_old[PC_W-1:0] = pc_reg;
            REG_FADDR: wr_old[FILE_AW-1:0] = faddr_reg;
            REG_FDATA: wr_old[DATA_W-1:0] = mem_rdata;
            REG_STATUS: begin
                wr_old[ST_Z_BIT] = z_reg;
                wr_old[ST_PD_BIT] = pd_reg;
                wr_old[ST_TO_BIT] = to_reg;
            end
            default: wr_old = '0;
        endcase
        wr_val = merge_strb(wr_old, w_data_reg, w_strb_reg);
    end

    // Execution datapath
    always_comb begin
        ex_res = '0;
        ex_wr_file = 1'b0;
        ex_wr_acc = 1'b0;
        ex_z_upd = 1'b0;
        ex_wdt_clr = 1'b0;
        ex_second = 1'b0;
        case (instr_reg.opcode)
            OPC_WDT_CLEAR: ex_wdt_clr = 1'b1;
            OPC_ACC_CALL: ex_second = 1'b1;
            OPC_COMPLEMENT: begin
                ex_res = ~mem_rdata;
                ex_wr_file = (instr_reg.dest == DEST_FILE);
                ex_wr_acc = (instr_reg.dest == DEST_ACC);
                ex_z_upd = 1'b1;
            end
            OPC_FILE_CLEAR: begin
                ex_res = '0;
                ex_wr_file = 1'b1;
                ex_z_upd = 1'b1;
            end
            OPC_DECREMENT: begin
                ex_res = mem_rdata - DATA_W'(1);
                ex_wr_file = (instr_reg.dest == DEST_FILE);
                ex_wr_acc = (instr_reg.dest == DEST_ACC);
                ex_z_upd = 1'b1;
            end
            OPC_ACC_CLEAR: begin
                ex_res = '0;
                ex_wr_acc = 1'b1;
                ex_z_upd = 1'b1;
            end
            OPC_DEC_SKIP: begin
                ex_res = mem_rdata - DATA_W'(1);
                ex_wr_file = (instr_reg.dest == DEST_FILE);
                ex_wr_acc = (instr_reg.dest == DEST_ACC);
                ex_second = (ex_res == '0);
            end
            default: ex_res = '0; // No-operation and unknown codes
        endcase
    end

    // Sequencer: fetch operand, execute, optional second cycle
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            state_reg <= EX_IDLE;
        end else begin
            case (state_reg)
                EX_IDLE: if (start) state_reg <= EX_FETCH;
                EX_FETCH: state_reg <= EX_EXEC;
                EX_EXEC: state_reg <= ex_second ? EX_SECOND : EX_IDLE;
                EX_SECOND: state_reg <= EX_IDLE;
                default: state_reg <= EX_IDLE;
            endcase
        end
    end

    // Command register and decoded instruction
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            cmd_reg <= '0;
            instr_reg <= '0;
        end else if (start) begin
            cmd_reg <= wr_val;
            instr_reg.opcode <= wr_val[CMD_OPC_LSB +: 4];
            instr_reg.faddr <= wr_val[CMD_F_LSB +: FILE_AW];
            instr_reg.dest <= wr_val[CMD_D_BIT];
        end
    end

    // Working accumulator, one writer at a time since writes wait for idle
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            acc_reg <= '0;
        end else if (in_exec && ex_wr_acc) begin
            acc_reg <= ex_res;
        end else if (wr_do && aw_addr_reg == REG_ACC) begin
            acc_reg <= wr_val[DATA_W-1:0];
        end
    end

    // Page latch and file window address
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            page_reg <= '0;
            faddr_reg <= '0;
        end else if (wr_do) begin
            if (aw_addr_reg == REG_PAGE) page_reg <= wr_val[PAGE_W-1:0];
            if (aw_addr_reg == REG_FADDR) faddr_reg <= wr_val[FILE_AW-1:0];
        end
    end

    // Program counter
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            pc_reg <= '0;
        end else if (in_exec) begin
            if (instr_reg.opcode == OPC_ACC_CALL) begin
                pc_reg <= {page_reg, acc_reg};
            end else begin
                pc_reg <= pc_reg + PC_W'(1);
            end
        end else if (state_reg == EX_SECOND && instr_reg.opcode == OPC_DEC_SKIP) begin
            pc_reg <= pc_reg + PC_W'(1); // Step over the discarded instruction
        end else if (wr_do && aw_addr_reg == REG_PC) begin
            pc_reg <= wr_val[PC_W-1:0];
        end
    end

    // Return address to the stack, pulse plus held value
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            O_STACK_PUSH <= 1'b0;
            O_STACK_TOP <= '0;
        end else begin
            O_STACK_PUSH <= in_exec && (instr_reg.opcode == OPC_ACC_CALL);
            if (in_exec && instr_reg.opcode == OPC_ACC_CALL) begin
                O_STACK_TOP <= pc_reg + PC_W'(1);
            end
        end
    end

    // Status flags; hardware events beat a software write in the same cycle
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            z_reg <= ST_Z_RST;
            pd_reg <= ST_PD_RST;
            to_reg <= ST_TO_RST;
        end else begin
            if (wr_do && aw_addr_reg == REG_STATUS) begin
                z_reg <= wr_val[ST_Z_BIT];
                pd_reg <= wr_val[ST_PD_BIT];
                to_reg <= wr_val[ST_TO_BIT];
            end
            if (in_exec && ex_z_upd) begin
                z_reg <= (ex_res == '0);
            end
            if (timeout) begin
                to_reg <= 1'b0; // Watchdog expiry, active-low flag
            end
            if (in_exec && ex_wdt_clr) begin
                to_reg <= 1'b1;
                pd_reg <= 1'b1;
            end
        end
    end

    // Watchdog prescaler and counter; expiry wraps and keeps counting
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            wdt_reg <= '0;
            presc_reg <= '0;
        end else if (in_exec && ex_wdt_clr) begin
            wdt_reg <= '0;
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + PRESC_W'(1);
            if (&presc_reg) wdt_reg <= wdt_reg + WDT_W'(1);
        end
    end

    // Instruction cycles retired
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            cycles_reg <= '0;
        end else if (in_exec || state_reg == EX_SECOND) begin
            cycles_reg <= cycles_reg + AXI_DW'(1);
        end
    end

    // File array port steering
    always_comb begin
        mem_raddr = (state_reg == EX_IDLE) ? faddr_reg : instr_reg.faddr;
        mem_we = 1'b0;
        mem_waddr = faddr_reg;
        mem_wdata = wr_val[DATA_W-1:0];
        if (in_exec && ex_wr_file) begin
            mem_we = 1'b1;
            mem_waddr = instr_reg.faddr;
            mem_wdata = ex_res;
        end else if (wr_do && aw_addr_reg == REG_FDATA) begin
            mem_we = 1'b1;
        end
    end

    cie_file_mem #(
        .AW(FILE_AW),
        .DW(DATA_W)
    ) u_file_mem (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );
endmodule // cie_core

// [hw/cie_file_mem.sv]
`timescale 1ns/1ns
// File register array with registered read data
module cie_file_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_reg [0:(1<<AW)-1]; // Storage, no reset on purpose

    // Write port
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    // Read port, one cycle of latency
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_reg[i_raddr];
        end
    end
endmodule // cie_file_mem

// [hw/cie_pkg.sv]
package cie_pkg;

    // Bus geometry
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int AXI_SW = 4;

    // Register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_PAGE = 8'h0C;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_WDT = 8'h14;
    localparam logic [7:0] REG_STACK = 8'h18;
    localparam logic [7:0] REG_FADDR = 8'h1C;
    localparam logic [7:0] REG_FDATA = 8'h20;
    localparam logic [7:0] REG_CYCLES = 8'h24;

    // Core widths
    localparam int FILE_AW = 7;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int PAGE_W = 7;

    // Command register fields
    localparam int CMD_OPC_LSB = 0;
    localparam int CMD_F_LSB = 8;
    localparam int CMD_D_BIT = 16;

    // Status register bits and watchdog prescaler field position
    localparam int ST_Z_BIT = 0;
    localparam int ST_PD_BIT = 1;
    localparam int ST_TO_BIT = 2;
    localparam int ST_BUSY_BIT = 8;
    localparam int WDT_PRESC_LSB = 16;

    // Reset values
    localparam logic ST_Z_RST = 1'b0;
    localparam logic ST_PD_RST = 1'b1;
    localparam logic ST_TO_RST = 1'b1;

    // Opcodes
    localparam logic [3:0] OPC_NOP = 4'h0;
    localparam logic [3:0] OPC_WDT_CLEAR = 4'h1;
    localparam logic [3:0] OPC_ACC_CALL = 4'h2;
    localparam logic [3:0] OPC_COMPLEMENT = 4'h3;
    localparam logic [3:0] OPC_FILE_CLEAR = 4'h4;
    localparam logic [3:0] OPC_DECREMENT = 4'h5;
    localparam logic [3:0] OPC_ACC_CLEAR = 4'h6;
    localparam logic [3:0] OPC_DEC_SKIP = 4'h7;

    // Destination selector values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One decoded instruction
    typedef struct packed {
        logic [3:0] opcode;
        logic [FILE_AW-1:0] faddr;
        logic dest;
    } cie_instr_t;

    // Execution sequencer states
    typedef enum logic [1:0] {
        EX_IDLE,
        EX_FETCH,
        EX_EXEC,
        EX_SECOND
    } cie_state_t;

endpackage

// [test/cie_core_asserts.sv]
`timescale 1ns/1ns
// Port-level checks of the instruction executor
module cie_core_asserts
    import cie_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic [AXI_AW-1:0] I_S_AXI_AWADDR,
    input wire logic I_S_AXI_AWVALID,
    input wire logic O_S_AXI_AWREADY,
    input wire logic [AXI_DW-1:0] I_S_AXI_WDATA,
    input wire logic [AXI_SW-1:0] I_S_AXI_WSTRB,
    input wire logic I_S_AXI_WVALID,
    input wire logic O_S_AXI_WREADY,
    input wire logic [1:0] O_S_AXI_BRESP,
    input wire logic O_S_AXI_BVALID,
    input wire logic I_S_AXI_BREADY,
    input wire logic [AXI_AW-1:0] I_S_AXI_ARADDR,
    input wire logic I_S_AXI_ARVALID,
    input wire logic O_S_AXI_ARREADY,
    input wire logic [AXI_DW-1:0] O_S_AXI_RDATA,
    input wire logic [1:0] O_S_AXI_RRESP,
    input wire logic O_S_AXI_RVALID,
    input wire logic I_S_AXI_RREADY,
    input wire logic O_STACK_PUSH,
    input wire logic [PC_W-1:0] O_STACK_TOP
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    // Address and data taken at one edge
    wire logic w_take = I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID && O_S_AXI_WREADY;
    // Command write, split by opcode
    wire logic cmd_wr = w_take && I_S_AXI_AWADDR == REG_CMD && I_S_AXI_WSTRB[0];
    wire logic call_wr = cmd_wr && I_S_AXI_WDATA[3:0] == OPC_ACC_CALL;

    b_answer_a: assert property (w_take |-> ##[1:8] O_S_AXI_BVALID)
        else $error("write response missing");
    b_hold_a: assert property (O_S_AXI_BVALID && !I_S_AXI_BREADY |=>
        O_S_AXI_BVALID && $stable(O_S_AXI_BRESP)) else $error("write response dropped");
    r_answer_a: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |-> ##[2:10] O_S_AXI_RVALID)
        else $error("read response missing");
    r_hold_a: assert property (O_S_AXI_RVALID && !I_S_AXI_RREADY |=>
        O_S_AXI_RVALID && $stable(O_S_AXI_RDATA)) else $error("read data dropped");
    w_busy_a: assert property (w_take |=> !O_S_AXI_AWREADY && !O_S_AXI_WREADY)
        else $error("ready stayed high while holding a write");
    call_push_a: assert property (call_wr |-> ##[1:8] O_STACK_PUSH)
        else $error("call did not push");
    push_pulse_a: assert property (O_STACK_PUSH |=> !O_STACK_PUSH)
        else $error("push longer than one cycle");
    no_push_a: assert property (cmd_wr && !call_wr |=> !O_STACK_PUSH [*8])
        else $error("push without a call");
    top_moves_a: assert property ($changed(O_STACK_TOP) |->
        (O_STACK_PUSH || $past(O_STACK_PUSH)) or ##1 O_STACK_PUSH)
        else $error("stack top moved without a push");

    // Main scenarios reached
    cover property (call_wr);
    cover property (O_STACK_PUSH);
    cover property (O_S_AXI_RVALID && O_S_AXI_RRESP == RESP_SLVERR);
endmodule // cie_core_asserts

bind cie_core cie_core_asserts chk_u (.*);

// [test/cie_core_tb.sv]
`timescale 1ns/1ns
// Self-checking bench: driver notes expectations, monitor compares
module cie_core_tb;
    import cie_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, push;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd_data;
    logic [14:0] top;
    // Expected {resp, data} with compare mask, oldest first
    logic [33:0] q_exp[$];
    logic [33:0] q_msk[$];
    logic [14:0] q_top[$];
    logic [33:0] got;
    // Reference state of the core
    logic [7:0] acc_m, page_m;
    logic [2:0] st_m;
    logic [14:0] pc_m;
    logic [31:0] cyc_m = 32'h0;
    logic [31:0] seed = 32'h47;
    int error_cnt = 0;
    int total_checks = 0;

    cie_core dut_u (.I_CORE_CLK(clk), .I_NRST(nrst), .I_S_AXI_AWADDR(awaddr),
        .I_S_AXI_AWVALID(awvalid), .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata),
        .I_S_AXI_WSTRB(4'hF), .I_S_AXI_WVALID(wvalid), .O_S_AXI_WREADY(wready),
        .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready),
        .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid), .O_S_AXI_ARREADY(arready),
        .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid),
        .I_S_AXI_RREADY(rready), .O_STACK_PUSH(push), .O_STACK_TOP(top));

    // Free-running core clock
    initial forever #25 clk = ~clk;

    // Xorshift source for operands
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Bound used up: count and stop
    task automatic give_up();
        error_cnt++;
        report_and_stop();
    endtask

    // Masked compare of one bus answer
    task automatic cmp(input logic [33:0] g, input logic [33:0] e, input logic [33:0] m);
        total_checks++;
        if (((g ^ e) & m) !== 34'h0) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Bus write; address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        int n;
        q_exp.push_back({r, 32'h0});
        q_msk.push_back({2'h3, 32'h0});
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (n == 60) give_up();
    endtask

    // Bus read; the answer is judged by the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
        input logic [1:0] r = RESP_OKAY);
        int n;
        q_exp.push_back({r, e});
        q_msk.push_back({2'h3, m});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd_data = rdata;
        rready <= 1'b0;
        if (n == 60) give_up();
    endtask

    // One instruction on random state, every result checked
    task automatic run_op(input logic [3:0] op, input logic d, input logic [7:0] v);
        logic [7:0] f, r;
        logic [6:0] fa;
        logic [14:0] ret;
        int n;
        fa = 7'(rnd());
        acc_m = 8'(rnd());
        page_m = {1'b0, 7'(rnd())};
        st_m = 3'(rnd());
        pc_m = 15'(rnd());
        wr(REG_FADDR, {25'h0, fa});
        wr(REG_FDATA, {24'h0, v});
        wr(REG_ACC, {24'h0, acc_m});
        wr(REG_PAGE, {24'h0, page_m});
        wr(REG_PC, {17'h0, pc_m});
        wr(REG_STATUS, {29'h0, st_m});
        wr(REG_CMD, {15'h0, d, 1'b0, fa, 4'h0, op});
        f = v;
        ret = pc_m + 15'h1;
        r = (op == OPC_COMPLEMENT) ? ~v : v - 8'h01;
        pc_m = ret;
        cyc_m = cyc_m + 32'h1;
        case (op)
            OPC_WDT_CLEAR: st_m[2:1] = 2'b11;
            OPC_ACC_CALL: begin
                pc_m = {page_m[6:0], acc_m};
                cyc_m = cyc_m + 32'h1;
                q_top.push_back(ret);
            end
            OPC_COMPLEMENT, OPC_DECREMENT: begin
                st_m[0] = (r == 8'h00);
                if (d) f = r;
                else acc_m = r;
            end
            OPC_FILE_CLEAR: begin
                f = 8'h00;
                st_m[0] = 1'b1;
            end
            OPC_ACC_CLEAR: begin
                acc_m = 8'h00;
                st_m[0] = 1'b1;
            end
            OPC_DEC_SKIP: begin
                if (d) f = r;
                else acc_m = r;
                if (r == 8'h00) begin
                    pc_m = pc_m + 15'h1;
                    cyc_m = cyc_m + 32'h1;
                end
            end
            default: ;
        endcase
        // Poll until idle; only the response code is judged
        for (n = 0; n < 20; n++) begin
            rd(REG_STATUS, 32'h0, 32'h0);
            if (rd_data[ST_BUSY_BIT] === 1'b0) break;
        end
        if (n == 20) give_up();
        if (op == OPC_WDT_CLEAR) rd(REG_WDT, 32'h0, 32'h00E000FF);
        if (op == OPC_ACC_CALL) rd(REG_STACK, {17'h0, ret});
        rd(REG_ACC, {24'h0, acc_m}, 32'hFF);
        rd(REG_FDATA, {24'h0, f}, 32'hFF);
        rd(REG_STATUS, {29'h0, st_m}, 32'h7);
        rd(REG_PC, {17'h0, pc_m}, 32'h7FFF);
        rd(REG_CYCLES, cyc_m);
    endtask

    // Monitor: each bus answer and stack push takes the oldest note
    always @(posedge clk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            got = bvalid ? {bresp, 32'h0} : {rresp, rdata};
            if (q_exp.size() == 0) cmp(got, ~got, '1);
            else cmp(got, q_exp.pop_front(), q_msk.pop_front());
        end
        if (push === 1'b1) begin
            if (q_top.size() == 0) cmp({19'h0, top}, ~{19'h0, top}, '1);
            else cmp({19'h0, top}, {19'h0, q_top.pop_front()}, '1);
        end
    end

    // Main sequence: reset, unmapped place, then every opcode both ways
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(REG_STATUS, {23'h0, 1'b0, 5'h0, ST_TO_RST, ST_PD_RST, ST_Z_RST}, 32'h107);
        wr(8'h3C, 32'h1, RESP_SLVERR);
        rd(8'h3C, 32'h0, '1, RESP_SLVERR);
        // Let the watchdog count leave zero
        repeat (300) @(posedge clk);
        for (int k = 0; k < 48; k++) begin
            run_op(k[2:0], k[3], k < 16 ? 8'h01 : (k < 32 ? 8'hFF : 8'(rnd())));
        end
        repeat (4) @(posedge clk);
        if (q_top.size() != 0) cmp(34'h0, 34'h1, '1);
        report_and_stop();
    end
endmodule // cie_core_tb
